// ==== bench/tag_access_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Port timing checks.
// ****
module tag_access_checker #(
  parameter [63:0] UNIQUE_ID = 64'h0000000000000000
) (
  input wire logic        clk,              // Clock.
  input wire logic        rst_n,            // Reset.
  input wire logic        avsRead,          // Bus read.
  input wire logic        avsWrite,         // Bus write.
  input wire logic        avsWaitrequest,   // Bus wait.
  input wire logic        rfReq,            // Rf request.
  input wire logic        rfDone,           // Rf done.
  input wire logic        rfRefused,        // Rf refusal.
  input wire logic [31:0] rfReadData,       // Rf data.
  input wire logic        serReq,           // Serial request.
  input wire logic [7:0]  serSelect,        // Select code.
  input wire logic        serDone,          // Serial done.
  input wire logic        serRefused,       // Serial refusal.
  input wire logic [7:0]  serReadData,      // Serial data.
  input wire logic [63:0] uniqueIdentifier  // Identifier.
);
  logic rfBusy;
  logic serBusy;

  // A request seen while one is pending is ignored, so only fresh ones start a count.
  always @(posedge clk) rfBusy <= rst_n && !rfDone && (rfReq || rfBusy);
  always @(posedge clk) serBusy <= rst_n && !serDone && (serReq || serBusy);

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wait_pulse: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_answer: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus request not answered next cycle");
  a_wait_cause: assert property (!avsWaitrequest |-> $past(avsRead || avsWrite))
    else $error("bus answer without request");
  a_rf_latency: assert property (rfReq && !rfBusy |-> ##[4:7] rfDone)
    else $error("rf request not completed in time");
  a_ser_latency: assert property (serReq && !serBusy |-> ##[4:7] serDone)
    else $error("serial request not completed in time");
  a_rf_refuse_zero: assert property (rfDone && rfRefused |-> rfReadData == 32'h00000000)
    else $error("refused rf access returned data");
  a_ser_refuse_zero: assert property (serDone && serRefused |-> serReadData == 8'h00)
    else $error("refused serial access returned data");
  a_rf_data_stands: assert property (!rfDone && $past(rst_n) |-> $stable(rfReadData))
    else $error("rf result changed without completion");
  a_rf_flag_early: assert property ($changed(rfRefused) |=> rfDone)
    else $error("rf refusal changed outside a completion");
  a_uid_fixed: assert property ($past(rst_n) |-> uniqueIdentifier == UNIQUE_ID)
    else $error("identifier differs from fixed value");
  a_sys_readonly: assert property (serReq && !serBusy && serSelect[3] && !serSelect[0] |-> ##[4:7] (serDone && serRefused))
    else $error("system area write not refused");

  c_rf_refused: cover property (rfDone && rfRefused);
  c_ser_done: cover property (serDone && !serRefused);
  c_bus_answer: cover property (avsRead && !avsWaitrequest);
endmodule // tag_access_checker

bind tag_user_memory_access_control tag_access_checker #(.UNIQUE_ID(UNIQUE_ID)) i_tag_access_checker (
  .clk(clk), .rst_n(rst_n), .avsRead(avsRead), .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest),
  .rfReq(rfReq), .rfDone(rfDone), .rfRefused(rfRefused), .rfReadData(rfReadData), .serReq(serReq),
  .serSelect(serSelect), .serDone(serDone), .serRefused(serRefused), .serReadData(serReadData),
  .uniqueIdentifier(uniqueIdentifier));
`default_nettype wire

// ==== bench/tag_far_side.sv ====
`include "tag_access_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// ****
// Reader and serial master model.
// ****
module tag_far_side (
  input  wire logic        clk,          // Clock.
  input  wire logic        rfDone,       // Rf done.
  input  wire logic        rfRefused,    // Rf refusal.
  input  wire logic [31:0] rfReadData,   // Rf data.
  input  wire logic        serDone,      // Serial done.
  input  wire logic        serRefused,   // Serial refusal.
  input  wire logic [7:0]  serReadData,  // Serial data.
  output var  logic        rfReq,        // Rf request.
  output var  logic [1:0]  rfCmd,        // Rf command.
  output var  logic [10:0] rfBlockAddr,  // Block address.
  output var  logic [31:0] rfWriteData,  // Block data.
  output var  logic [1:0]  rfPwdSel,     // Password number.
  output var  logic [4:0]  rfNewStatus,  // New status.
  output var  logic        serReq,       // Serial request.
  output var  logic [7:0]  serSelect,    // Select code.
  output var  logic [12:0] serByteAddr,  // Byte address.
  output var  logic [7:0]  serWriteData  // Byte data.
);
  initial {rfReq, rfCmd, rfBlockAddr, rfWriteData, rfPwdSel, rfNewStatus} = '0;
  initial {serReq, serSelect, serByteAddr, serWriteData} = '0;

  // Write data is inverted after each transfer so that stale data never looks valid.
  task automatic rfOp(input logic [1:0] c, input logic [10:0] a, input logic [31:0] d,
    input logic [1:0] p, input logic [4:0] s, output logic isRef, output logic [31:0] rd,
    output logic ok);
    int n;
    begin
      @(posedge clk);
      {rfReq, rfCmd, rfBlockAddr, rfWriteData, rfPwdSel, rfNewStatus} <= {1'b1, c, a, d, p, s};
      @(posedge clk);
      rfReq <= 1'b0;
      n = 0;
      while (rfDone !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      isRef = rfRefused;
      rd = rfReadData;
      ok = n < 20;
      rfWriteData <= ~d;
    end
  endtask

  task automatic serOp(input logic area, input logic [1:0] ce, input logic rw,
    input logic [12:0] a, input logic [7:0] d, output logic isRef, output logic [7:0] rd,
    output logic ok);
    int n;
    begin
      @(posedge clk);
      {serReq, serSelect, serByteAddr, serWriteData} <= {1'b1, `DSC_TYPE_CODE, area, ce, rw, a, d};
      @(posedge clk);
      serReq <= 1'b0;
      n = 0;
      while (serDone !== 1'b1 && n < 20) begin
        @(posedge clk);
        n++;
      end
      isRef = serRefused;
      rd = serReadData;
      ok = n < 20;
      serWriteData <= ~d;
    end
  endtask
endmodule // tag_far_side
`default_nettype wire

// ==== bench/tag_user_memory_access_control_tb.sv ====
`include "tag_access_defines.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
// ****
// Bench top.
// ****
module tag_user_memory_access_control_tb;
  localparam logic [63:0] UNIQUE_IDENTIFIER = 64'h5A5A0F0F3C3C9696; // Arbitrary value.
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [8:0]  avsAddress = 9'h000;
  logic [31:0] avsWritedata = 32'h00000000;
  logic [1:0]  chipEnable = 2'h2;
  logic        isRefused, isOk;
  logic [31:0] rd;
  logic [7:0]  sb;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  wire [31:0] avsReaddata, rfReadData, rfWriteData;
  wire        avsWaitrequest, rfReq, rfDone, rfRefused, serReq, serDone, serRefused;
  wire [1:0]  rfCmd, rfPwdSel;
  wire [10:0] rfBlockAddr;
  wire [4:0]  rfNewStatus;
  wire [7:0]  serSelect, serWriteData, serReadData, applicationFamilyId, storageFamilyId;
  wire [12:0] serByteAddr;
  wire [63:0] uniqueIdentifier;

  initial forever #12.5 clk = ~clk;

  tag_user_memory_access_control #(.UNIQUE_ID(UNIQUE_IDENTIFIER)) i_tag_user_memory_access_control (
    .clk(clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
    .rfReq(rfReq), .rfCmd(rfCmd), .rfBlockAddr(rfBlockAddr), .rfWriteData(rfWriteData),
    .rfPwdSel(rfPwdSel), .rfNewStatus(rfNewStatus), .rfDone(rfDone), .rfRefused(rfRefused),
    .rfReadData(rfReadData), .serReq(serReq), .serSelect(serSelect), .chipEnable(chipEnable),
    .serByteAddr(serByteAddr), .serWriteData(serWriteData), .serDone(serDone),
    .serRefused(serRefused), .serReadData(serReadData), .uniqueIdentifier(uniqueIdentifier),
    .applicationFamilyId(applicationFamilyId), .storageFamilyId(storageFamilyId));
  tag_far_side i_tag_far_side (
    .clk(clk), .rfDone(rfDone), .rfRefused(rfRefused), .rfReadData(rfReadData),
    .serDone(serDone), .serRefused(serRefused), .serReadData(serReadData), .rfReq(rfReq),
    .rfCmd(rfCmd), .rfBlockAddr(rfBlockAddr), .rfWriteData(rfWriteData), .rfPwdSel(rfPwdSel),
    .rfNewStatus(rfNewStatus), .serReq(serReq), .serSelect(serSelect),
    .serByteAddr(serByteAddr), .serWriteData(serWriteData));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic hang(input string nm);
    n_mismatch++;
    $display("Error %s timed out", nm);
    finish_test();
  endtask

  task automatic avXfer(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      {avsAddress, avsWritedata, avsWrite, avsRead} <= {a, d, wr, !wr};
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (avsWaitrequest !== 1'b0 && n < 20);
      rd = avsReaddata;
      {avsWrite, avsRead} <= 2'b00;
      if (n >= 20) hang("bus");
    end
  endtask

  task automatic rf(input logic [1:0] c, input logic [10:0] a, input logic [31:0] d,
    input logic [1:0] p, input logic [4:0] s);
    i_tag_far_side.rfOp(c, a, d, p, s, isRefused, rd, isOk);
    if (isOk !== 1'b1) hang("rf");
  endtask

  task automatic ser(input logic ar, input logic [1:0] ce, input logic rw, input logic [12:0] a,
    input logic [7:0] d);
    i_tag_far_side.serOp(ar, ce, rw, a, d, isRefused, sb, isOk);
    if (isOk !== 1'b1) hang("serial");
  endtask

  task automatic t_regs();
    `CHK("waitrequest", 1'b1, avsWaitrequest)
    avXfer(1'b1, `REG_APP_FAMILY, 32'h0000005A);
    avXfer(1'b1, `REG_STORE_FAMILY, 32'h000000C3);
    avXfer(0, `REG_APP_FAMILY, 32'h00000000);
    `CHK("app family read", 32'h0000005A, rd)
    `CHK("app family port", 8'h5A, applicationFamilyId)
    `CHK("storage family port", 8'hC3, storageFamilyId)
    avXfer(1'b1, `REG_RF_PWD2, 32'hDEADBEEF);
    avXfer(0, `REG_RF_PWD2, 32'h00000000);
    `CHK("password read", 32'h00000000, rd)
    avXfer(0, 9'h040, 32'h00000000);
    `CHK("unmapped read", 32'h00000000, rd)
    `CHK("identifier", UNIQUE_IDENTIFIER, uniqueIdentifier)
    $display("test regs done");
  endtask

  task automatic t_map();
    rf(`RF_CMD_WRITE, 11'h7FF, 32'hA1B2C3D4, 2'h0, 5'h00);
    `CHK("last block write", 1'b0, isRefused)
    for (int k = 0; k < 4; k++) begin
      ser(1'b0, 2'h2, 1'b1, 13'(13'h1FFC + k), 8'h00);
      `CHK("serial byte", 8'(32'hA1B2C3D4 >> (8 * k)), sb)
    end
    rf(`RF_CMD_WRITE, 11'h005, 32'h11223344, 2'h0, 5'h00);
    ser(1'b0, 2'h2, 1'b0, 13'h0016, 8'h77);
    `CHK("byte write", 1'b0, isRefused)
    rf(`RF_CMD_READ, 11'h005, 32'h00000000, 2'h0, 5'h00);
    `CHK("merged block", 32'h11773344, rd)
    rf(`RF_CMD_WRITE, 11'h005, 32'h00000000, 2'h0, 5'h00);
    rf(`RF_CMD_READ, 11'h005, 32'h00000000, 2'h0, 5'h00);
    `CHK("whole block", 32'h00000000, rd)
    $display("test map done");
  endtask

  task automatic t_prot();
    avXfer(1'b1, 9'h104, 32'h00000001);
    rf(`RF_CMD_READ, 11'h028, 32'h00000000, 2'h0, 5'h00);
    `CHK("read protected", 1'b1, isRefused)
    rf(`RF_CMD_WRITE, 11'h040, 32'h00000040, 2'h0, 5'h00);
    rf(`RF_CMD_READ, 11'h040, 32'h00000000, 2'h0, 5'h00);
    `CHK("next sector read", 1'b0, isRefused)
    `CHK("next sector data", 32'h00000040, rd)
    rf(`RF_CMD_WRITE, 11'h028, 32'h0BAD0BAD, 2'h0, 5'h00);
    `CHK("write allowed", 1'b0, isRefused)
    rf(`RF_CMD_PROTECT, 11'h028, 32'h00000000, 2'h0, 5'h02);
    `CHK("no password", 1'b1, isRefused)
    rf(`RF_CMD_PROTECT, 11'h028, 32'h00001234, 2'h1, 5'h02);
    `CHK("bad password", 1'b1, isRefused)
    rf(`RF_CMD_PROTECT, 11'h028, 32'h00000000, 2'h1, 5'h02);
    `CHK("good password", 1'b0, isRefused)
    avXfer(0, 9'h104, 32'h00000000);
    `CHK("new status", 32'h00000002, rd)
    rf(`RF_CMD_WRITE, 11'h03F, 32'hFFFFFFFF, 2'h0, 5'h00);
    `CHK("write protected", 1'b1, isRefused)
    rf(`RF_CMD_WRITE, 11'h028, 32'hFFFFFFFF, 2'h0, 5'h00);
    rf(`RF_CMD_READ, 11'h028, 32'h00000000, 2'h0, 5'h00);
    `CHK("block kept", 32'h0BAD0BAD, rd)
    rf(2'h3, 11'h005, 32'h00000000, 2'h0, 5'h00);
    `CHK("unknown command", 1'b1, isRefused)
    $display("test protect done");
  endtask

  task automatic t_lock();
    avXfer(1'b1, `REG_LOCK_LOW, 32'h00000008);
    ser(1'b0, 2'h2, 1'b0, 13'h01FF, 8'h55);
    `CHK("locked byte", 1'b1, isRefused)
    ser(1'b0, 2'h2, 1'b0, 13'h0200, 8'h66);
    `CHK("open byte", 1'b0, isRefused)
    ser(1'b0, 2'h2, 1'b1, 13'h0200, 8'h00);
    `CHK("open byte read", 8'h66, sb)
    ser(1'b1, 2'h2, 1'b1, 13'h0000, 8'h00);
    `CHK("lock byte read", 8'h08, sb)
    ser(1'b1, 2'h2, 1'b0, 13'h0000, 8'hFF);
    `CHK("system write", 1'b1, isRefused)
    ser(1'b1, 2'h2, 1'b1, 13'h0008, 8'h00);
    `CHK("system range", 1'b1, isRefused)
    ser(1'b0, 2'h1, 1'b1, 13'h0200, 8'h00);
    `CHK("wrong chip enable", 1'b1, isRefused)
    $display("test lock done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_map();
    t_prot();
    t_lock();
    finish_test();
  end
endmodule // tag_user_memory_access_control_tb
`default_nettype wire

// ==== hw/tag_access_defines.vh ====
`ifndef TAG_ACCESS_DEFINES_VH
`define TAG_ACCESS_DEFINES_VH

// ****************************************************************
// Memory geometry.
// ****************************************************************
`define SECTOR_COUNT     64
`define BLOCKS_PER_SECT  32
`define BYTES_PER_SECT   128
`define BLOCK_COUNT      2048
`define BLOCK_ADDR_W     11
`define BYTE_ADDR_W      13
`define SECT_W           6
`define SEC_STATUS_W     5

// ****************************************************************
// Sector security status bits and contactless commands.
// ****************************************************************
`define SEC_READ_PROT    0
`define SEC_WRITE_PROT   1
`define RF_CMD_READ      2'h0
`define RF_CMD_WRITE     2'h1
`define RF_CMD_PROTECT   2'h2

// ****************************************************************
// Serial device select code fields.
// ****************************************************************
`define DSC_TYPE_CODE    4'hA
`define DSC_AREA_BIT     3
`define SYS_LOCK_BYTES   13'h0008

// ****************************************************************
// Register map, byte addresses.
// ****************************************************************
`define REG_APP_FAMILY   9'h000
`define REG_STORE_FAMILY 9'h004
`define REG_SERIAL_PWD   9'h008
`define REG_RF_PWD1      9'h00C
`define REG_RF_PWD2      9'h010
`define REG_RF_PWD3      9'h014
`define REG_LOCK_LOW     9'h018
`define REG_LOCK_HIGH    9'h01C
`define REG_STATUS       9'h020
`define REG_SECTOR_BASE  9'h100

// ****************************************************************
// Reset values.
// ****************************************************************
`define RST_FAMILY       8'h00
`define RST_PASSWORD     32'h00000000
`define RST_SEC_STATUS   5'h00

`endif

// ==== hw/tag_block_ram.v ====
`timescale 1ns/1ps
`default_nettype none

module tag_block_ram (
  input  wire        clk,        // System clock.
  input  wire [10:0] addr,       // Block address.
  input  wire [3:0]  byteWrite,  // Per-byte write strobes.
  input  wire [31:0] writeData,  // Write data.
  output reg  [31:0] readData    // Registered read data.
);

  // ****************************************************************
  // One byte lane per generate entry, each with its own storage.
  // ****************************************************************
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : gLane
      reg [7:0] store [0:2047];
      always @(posedge clk) begin
        if (byteWrite[lane]) begin
          store[addr] <= writeData[8*lane+7:8*lane];
        end
        readData[8*lane+7:8*lane] <= store[addr];
      end
    end
  endgenerate

endmodule // tag_block_ram

`default_nettype wire

// ==== hw/tag_user_memory_access_control.v ====
// Behaviour
// - User memory is 64 sectors of 32 blocks of 32 bits.
// - Each sector separately read and/or write protectable via password command.
// - Contactless access to protected sector data is refused, otherwise performed.
// - Holds a fixed 64-bit unique identifier for the inventory sequence.
// - Unique identifier is never writable or readable by the user.
// - Provides 8-bit application and storage family identifier registers.
// - One serial password and three contactless passwords, 32 bits each.
// - Every sector is 1024 bits from either interface.
// - Contactless reads and writes move one 32-bit block.
// - Contactless access to a sector follows its 5-bit security status.
// - Contactless write to an open sector replaces all 32 block bits.
// - Serial side sees each sector as 128 individually accessible bytes.
// - Serial writes to a sector with its write-lock bit set are blocked.
// - Area select bit b3 is decoded internally to pick user or system.
`include "tag_access_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tag_user_memory_access_control #(
  parameter [63:0] UNIQUE_ID = 64'h0123456789ABCDEF  // Arbitrary value.
) (
  input  wire        clk,                 // 40 MHz clock.
  input  wire        rst_n,               // Synchronous reset, active low.
  input  wire [8:0]  avsAddress,          // Avalon byte address.
  input  wire        avsRead,             // Avalon read.
  input  wire        avsWrite,            // Avalon write.
  input  wire [31:0] avsWritedata,        // Avalon write data.
  output reg  [31:0] avsReaddata,         // Avalon read data.
  output reg         avsWaitrequest,      // Avalon wait request.
  input  wire        rfReq,               // Contactless request pulse.
  input  wire [1:0]  rfCmd,               // Read, write or protect.
  input  wire [10:0] rfBlockAddr,         // Block address.
  input  wire [31:0] rfWriteData,         // Block data or password.
  input  wire [1:0]  rfPwdSel,            // Password number 1 to 3.
  input  wire [4:0]  rfNewStatus,         // Security status to set.
  output reg         rfDone,              // Completion pulse.
  output reg         rfRefused,           // Refusal flag with rfDone.
  output reg  [31:0] rfReadData,          // Block read data.
  input  wire        serReq,              // Serial request pulse.
  input  wire [7:0]  serSelect,           // Device select code with RW.
  input  wire [1:0]  chipEnable,          // Chip enable straps.
  input  wire [12:0] serByteAddr,         // Byte address.
  input  wire [7:0]  serWriteData,        // Byte write data.
  output reg         serDone,             // Completion pulse.
  output reg         serRefused,          // Refusal flag with serDone.
  output reg  [7:0]  serReadData,         // Byte read data.
  output reg  [63:0] uniqueIdentifier,    // Identifier for inventory.
  output reg  [7:0]  applicationFamilyId, // Application family register.
  output reg  [7:0]  storageFamilyId      // Storage family register.
);

  localparam [1:0] ST_IDLE   = 2'h0;
  localparam [1:0] ST_ACCESS = 2'h1;
  localparam [1:0] ST_FINISH = 2'h2;

  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg         ownerRf;
  reg         rfPend;
  reg         serPend;
  reg  [1:0]  rfCmdHold;
  reg  [10:0] rfAddrHold;
  reg  [31:0] rfDataHold;
  reg  [1:0]  rfPwdHold;
  reg  [4:0]  rfStatusHold;
  reg  [7:0]  serSelHold;
  reg  [12:0] serAddrHold;
  reg  [7:0]  serDataHold;
  reg  [31:0] serialPwd;
  reg  [31:0] rfPwd1;
  reg  [31:0] rfPwd2;
  reg  [31:0] rfPwd3;
  reg  [63:0] writeLock;
  reg  [4:0]  secStatus [0:63];
  reg  [15:0] refuseCount;
  reg         refuse;
  reg  [3:0]  byteWrite;
  reg  [31:0] ramWrite;
  reg  [10:0] ramAddr;
  reg  [31:0] pwdPick;
  reg  [31:0] next_readData;
  wire [31:0] ramRead;
  wire [5:0]  rfSector;
  wire [5:0]  serSector;
  wire        serRead;
  wire        serSystem;
  wire        serSelectOk;
  wire        avsTake;

  assign rfSector    = rfAddrHold[10:5];
  assign serSector   = serAddrHold[12:7];
  assign serRead     = serSelHold[0];
  assign serSystem   = serSelHold[`DSC_AREA_BIT];
  assign serSelectOk = (serSelHold[7:4] == `DSC_TYPE_CODE) && (serSelHold[2:1] == chipEnable);
  assign avsTake     = (avsRead || avsWrite) && !avsWaitrequest;

  // ****************************************************************
  // Block storage shared by both interfaces.
  // ****************************************************************
  tag_block_ram i_tag_block_ram (
    .clk       (clk),
    .addr      (ramAddr),
    .byteWrite (byteWrite),
    .writeData (ramWrite),
    .readData  (ramRead)
  );

  // ****************************************************************
  // Access check and memory port drive.
  // ****************************************************************
  always @* begin
    refuse   = 1'b0;
    pwdPick  = rfPwd1;
    if (rfPwdHold == 2'h2) begin
      pwdPick = rfPwd2;
    end else if (rfPwdHold == 2'h3) begin
      pwdPick = rfPwd3;
    end
    if (ownerRf) begin
      if (rfCmdHold == `RF_CMD_READ) begin
        refuse = secStatus[rfSector][`SEC_READ_PROT];
      end else if (rfCmdHold == `RF_CMD_WRITE) begin
        refuse = secStatus[rfSector][`SEC_WRITE_PROT];
      end else if (rfCmdHold == `RF_CMD_PROTECT) begin
        refuse = (rfPwdHold == 2'h0) || (pwdPick != rfDataHold);
      end else begin
        refuse = 1'b1;
      end
    end else begin
      if (!serSelectOk) begin
        refuse = 1'b1;
      end else if (serSystem) begin
        refuse = !serRead || (serAddrHold >= `SYS_LOCK_BYTES);
      end else begin
        refuse = !serRead && writeLock[serSector];
      end
    end
  end

  always @* begin
    ramAddr   = ownerRf ? rfAddrHold : serAddrHold[12:2];
    ramWrite  = ownerRf ? rfDataHold : {4{serDataHold}};
    byteWrite = 4'h0;
    if (state == ST_ACCESS && !refuse) begin
      if (ownerRf && rfCmdHold == `RF_CMD_WRITE) begin
        byteWrite = 4'hF;
      end else if (!ownerRf && !serRead && !serSystem) begin
        byteWrite = 4'h1 << serAddrHold[1:0];
      end
    end
  end

  // ****************************************************************
  // Request capture and access sequencing.
  // ****************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (rfPend || serPend) begin
          next_state = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        next_state = ST_FINISH;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      ownerRf      <= 1'b0;
      rfPend       <= 1'b0;
      serPend      <= 1'b0;
      rfCmdHold    <= 2'h0;
      rfAddrHold   <= 11'h000;
      rfDataHold   <= 32'h00000000;
      rfPwdHold    <= 2'h0;
      rfStatusHold <= 5'h00;
      serSelHold   <= 8'h00;
      serAddrHold  <= 13'h0000;
      serDataHold  <= 8'h00;
      rfDone       <= 1'b0;
      rfRefused    <= 1'b0;
      rfReadData   <= 32'h00000000;
      serDone      <= 1'b0;
      serRefused   <= 1'b0;
      serReadData  <= 8'h00;
      refuseCount  <= 16'h0000;
    end else begin
      state   <= next_state;
      rfDone  <= 1'b0;
      serDone <= 1'b0;
      if (rfReq && !rfPend) begin
        rfPend       <= 1'b1;
        rfCmdHold    <= rfCmd;
        rfAddrHold   <= rfBlockAddr;
        rfDataHold   <= rfWriteData;
        rfPwdHold    <= rfPwdSel;
        rfStatusHold <= rfNewStatus;
      end
      if (serReq && !serPend) begin
        serPend     <= 1'b1;
        serSelHold  <= serSelect;
        serAddrHold <= serByteAddr;
        serDataHold <= serWriteData;
      end
      if (state == ST_IDLE && (rfPend || serPend)) begin
        ownerRf <= rfPend;
      end
      if (state == ST_ACCESS && refuse) begin
        refuseCount <= refuseCount + 16'h0001;
      end
      if (state == ST_ACCESS) begin
        if (ownerRf) begin
          rfRefused <= refuse;
        end else begin
          serRefused <= refuse;
        end
      end
      if (state == ST_FINISH) begin
        if (ownerRf) begin
          rfPend     <= 1'b0;
          rfDone     <= 1'b1;
          rfReadData <= (rfRefused || rfCmdHold != `RF_CMD_READ) ? 32'h00000000 : ramRead;
        end else begin
          serPend <= 1'b0;
          serDone <= 1'b1;
          if (serRefused || !serRead) begin
            serReadData <= 8'h00;
          end else if (serSystem) begin
            serReadData <= writeLock[{serAddrHold[2:0], 3'h0} +: 8];
          end else begin
            serReadData <= ramRead[{serAddrHold[1:0], 3'h0} +: 8];
          end
        end
      end
    end
  end

  // ****************************************************************
  // System area: identifiers, passwords, locks, security status.
  // ****************************************************************
  genvar s;
  generate
    for (s = 0; s < `SECTOR_COUNT; s = s + 1) begin : gSector
      always @(posedge clk) begin
        if (!rst_n) begin
          secStatus[s] <= `RST_SEC_STATUS;
        end else if (state == ST_ACCESS && ownerRf && !refuse &&
                     rfCmdHold == `RF_CMD_PROTECT && rfSector == s) begin
          secStatus[s] <= rfStatusHold;
        end else if (avsTake && avsWrite && avsAddress[8] && avsAddress[7:2] == s) begin
          secStatus[s] <= avsWritedata[4:0];
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (!rst_n) begin
      uniqueIdentifier    <= 64'h0000000000000000;
      applicationFamilyId <= `RST_FAMILY;
      storageFamilyId     <= `RST_FAMILY;
      serialPwd           <= `RST_PASSWORD;
      rfPwd1              <= `RST_PASSWORD;
      rfPwd2              <= `RST_PASSWORD;
      rfPwd3              <= `RST_PASSWORD;
      writeLock           <= 64'h0000000000000000;
    end else begin
      uniqueIdentifier <= UNIQUE_ID;
      if (avsTake && avsWrite) begin
        if (avsAddress == `REG_APP_FAMILY) begin
          applicationFamilyId <= avsWritedata[7:0];
        end else if (avsAddress == `REG_STORE_FAMILY) begin
          storageFamilyId <= avsWritedata[7:0];
        end else if (avsAddress == `REG_SERIAL_PWD) begin
          serialPwd <= avsWritedata;
        end else if (avsAddress == `REG_RF_PWD1) begin
          rfPwd1 <= avsWritedata;
        end else if (avsAddress == `REG_RF_PWD2) begin
          rfPwd2 <= avsWritedata;
        end else if (avsAddress == `REG_RF_PWD3) begin
          rfPwd3 <= avsWritedata;
        end else if (avsAddress == `REG_LOCK_LOW) begin
          writeLock[31:0] <= avsWritedata;
        end else if (avsAddress == `REG_LOCK_HIGH) begin
          writeLock[63:32] <= avsWritedata;
        end
      end
    end
  end

  // ****************************************************************
  // Avalon slave: one wait cycle, then a one-cycle answer.
  // ****************************************************************
  // Passwords read as zero so that software cannot recover them.
  always @* begin
    next_readData = 32'h00000000;
    if (avsAddress[8]) begin
      next_readData = {27'h0000000, secStatus[avsAddress[7:2]]};
    end else if (avsAddress == `REG_APP_FAMILY) begin
      next_readData = {24'h000000, applicationFamilyId};
    end else if (avsAddress == `REG_STORE_FAMILY) begin
      next_readData = {24'h000000, storageFamilyId};
    end else if (avsAddress == `REG_LOCK_LOW) begin
      next_readData = writeLock[31:0];
    end else if (avsAddress == `REG_LOCK_HIGH) begin
      next_readData = writeLock[63:32];
    end else if (avsAddress == `REG_STATUS) begin
      next_readData = {refuseCount, 12'h000, rfPend, serPend, state};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h00000000;
    end else if ((avsRead || avsWrite) && avsWaitrequest) begin
      avsWaitrequest <= 1'b0;
      avsReaddata    <= avsRead ? next_readData : 32'h00000000;
    end else begin
      avsWaitrequest <= 1'b1;
    end
  end

endmodule // tag_user_memory_access_control

`default_nettype wire
